// File: hw/np_tx_defs.vh
// Constants for the next page transmit register bank.
// Assumes inclusion by bare name from hw/.
`ifndef NP_TX_DEFS_VH
`define NP_TX_DEFS_VH
`define IND_CTRL_ADDR     8'h6E
`define IND_OFFSET_ADDR   8'h6F
`define IND_DATA_ADDR     8'hA0
`define FUNC_SEL_EEE      3'h1
`define FUNC_SEL_MSB      7
`define FUNC_SEL_LSB      5
`define PORT_SEL_MSB      3
`define PORT_SEL_LSB      0
`define NP_OFF_HIGH       8'h0E
`define NP_OFF_LOW        8'h0F
`define BIT_MORE_PAGES    15
`define BIT_RESERVED      14
`define BIT_PAGE_TYPE     13
`define BIT_COMPLY        12
`define BIT_TOGGLE        11
`define WORD_RESET        16'h2000
`define WORD_WR_MASK      16'hB7FF
`endif

// File: hw/an_next_page_tx_register.v
// Per-port next page transmit word behind an indirect byte window.
// Assumes a synchronous byte register port and an arbiter that pulses page_sent.
//
// Summary of operation
// - Offset byte selects target byte; data window reads and writes it.
// - Upper word byte sits at offset 0x0E, lower byte at 0x0F.
// - Bit 15 flags more pages follow; resets to 0.
// - Bit 13 writable page type, 1 message page, resets to 1.
// - Bit 12 signals ability to comply with received message.
// - Bit 11 toggle is read-only, inverts previous codeword toggle, resets 0.
// - First next page toggle is inverse of base codeword bit 11.
`include "np_tx_defs.vh"
module an_next_page_tx_register #(
  parameter NUM_PORTS = 3
) (
  input  wire                   clk_sys_in,
  input  wire                   arst_n_in,
  input  wire [7:0]             reg_addr_in,
  input  wire [7:0]             reg_wdata_in,
  input  wire                   reg_wr_in,
  input  wire                   reg_rd_in,
  output reg  [7:0]             reg_rdata_out,
  input  wire [NUM_PORTS-1:0]   auto_eee_in,
  input  wire [NUM_PORTS-1:0]   base_toggle_in,
  input  wire [NUM_PORTS-1:0]   base_sent_in,
  input  wire [NUM_PORTS-1:0]   page_sent_in,
  output wire [16*NUM_PORTS-1:0] np_word_out
);

  // ****************************************
  // Constants
  // ****************************************

  localparam [15:0] RESET_WORD = `WORD_RESET;

  // ****************************************
  // Decode helpers
  // ****************************************

  // Address match, shared by the write and read paths
  function addr_is;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // Port code 0 and codes above the port count are refused
  function port_legal;
    input [3:0] sel;
    begin
      port_legal = (sel != 4'h0) && ({28'h000_0000, sel} <= NUM_PORTS);
    end
  endfunction

  // ****************************************
  // Indirect control and offset
  // ****************************************

  reg  [7:0]  ctrl_byte;
  reg  [7:0]  offset_byte;
  reg  [7:0]  next_ctrl_byte;
  reg  [7:0]  next_offset_byte;
  wire        is_eee;
  wire [3:0]  port_sel;
  wire [31:0] port_num;
  wire        port_ok;
  wire        win_wr;
  wire        hit_high;
  wire        hit_low;

  assign is_eee   = (ctrl_byte[`FUNC_SEL_MSB:`FUNC_SEL_LSB] == `FUNC_SEL_EEE);
  assign port_sel = ctrl_byte[`PORT_SEL_MSB:`PORT_SEL_LSB];
  assign port_num = {28'h000_0000, port_sel};
  assign port_ok  = port_legal(port_sel);
  assign win_wr   = reg_wr_in && addr_is(reg_addr_in, `IND_DATA_ADDR) && is_eee && port_ok;
  assign hit_high = (offset_byte == `NP_OFF_HIGH);
  assign hit_low  = (offset_byte == `NP_OFF_LOW);

  always @* begin
    next_ctrl_byte   = ctrl_byte;
    next_offset_byte = offset_byte;
    if (reg_wr_in && addr_is(reg_addr_in, `IND_CTRL_ADDR)) begin
      next_ctrl_byte = reg_wdata_in;
    end
    if (reg_wr_in && addr_is(reg_addr_in, `IND_OFFSET_ADDR)) begin
      next_offset_byte = reg_wdata_in;
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_byte   <= 8'h00;
      offset_byte <= 8'h00;
    end else begin
      ctrl_byte   <= next_ctrl_byte;
      offset_byte <= next_offset_byte;
    end
  end

  // ****************************************
  // Per-port words
  // ****************************************

  wire [16*NUM_PORTS-1:0] word_flat;

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_port
      reg         more_pages_flag;
      reg         page_type_flag;
      reg         comply_flag;
      reg         toggle_bit;
      reg  [10:0] code_field;
      reg         next_more_pages_flag;
      reg         next_page_type_flag;
      reg         next_comply_flag;
      reg         next_toggle_bit;
      reg  [10:0] next_code_field;
      wire        sel;
      wire [15:0] word;

      assign sel = win_wr && (port_num == g + 1);

      // Software writes never reach the toggle or reserved bits
      always @* begin
        next_more_pages_flag = more_pages_flag;
        next_page_type_flag  = page_type_flag;
        next_comply_flag     = comply_flag;
        next_toggle_bit      = toggle_bit;
        next_code_field      = code_field;
        if (sel && hit_high) begin
          next_more_pages_flag  = reg_wdata_in[`BIT_MORE_PAGES-8];
          next_page_type_flag   = reg_wdata_in[`BIT_PAGE_TYPE-8];
          next_comply_flag      = reg_wdata_in[`BIT_COMPLY-8];
          next_code_field[10:8] = reg_wdata_in[2:0];
        end
        if (sel && hit_low) begin
          next_code_field[7:0] = reg_wdata_in;
        end
        // Base page wins: it restarts the toggle sequence
        if (base_sent_in[g]) begin
          next_toggle_bit = ~base_toggle_in[g];
        end else if (page_sent_in[g]) begin
          next_toggle_bit = ~toggle_bit;
        end
      end

      always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          more_pages_flag <= RESET_WORD[`BIT_MORE_PAGES];
          page_type_flag  <= RESET_WORD[`BIT_PAGE_TYPE];
          comply_flag     <= RESET_WORD[`BIT_COMPLY];
          toggle_bit      <= RESET_WORD[`BIT_TOGGLE];
          code_field      <= RESET_WORD[10:0];
        end else begin
          more_pages_flag <= next_more_pages_flag;
          page_type_flag  <= next_page_type_flag;
          comply_flag     <= next_comply_flag;
          toggle_bit      <= next_toggle_bit;
          code_field      <= next_code_field;
        end
      end

      // Reserved bit is a constant, so no write can ever reach it
      assign word = {more_pages_flag, 1'b0, page_type_flag, comply_flag, toggle_bit, code_field};

      assign word_flat[16*g+15:16*g] = word;

      // Auto mode: arbiter builds its own page, stored word is masked
      assign np_word_out[16*g+15:16*g] = auto_eee_in[g] ? 16'h0000 : word;
    end
  endgenerate

  // ****************************************
  // Read word select
  // ****************************************

  reg  [15:0] rd_word;
  integer     k;

  always @* begin
    rd_word = 16'h0000;
    for (k = 0; k < NUM_PORTS; k = k + 1) begin
      if (port_num == k + 1) begin
        rd_word = word_flat[16*k +: 16];
      end
    end
  end

  // ****************************************
  // Read window
  // ****************************************

  reg  [7:0] next_rdata;

  // Refused selections read as zero rather than a stale byte
  always @* begin
    next_rdata = reg_rdata_out;
    if (reg_rd_in) begin
      next_rdata = 8'h00;
      if (addr_is(reg_addr_in, `IND_CTRL_ADDR)) begin
        next_rdata = ctrl_byte;
      end else if (addr_is(reg_addr_in, `IND_OFFSET_ADDR)) begin
        next_rdata = offset_byte;
      end else if (addr_is(reg_addr_in, `IND_DATA_ADDR) && is_eee && port_ok) begin
        if (hit_high) begin
          next_rdata = rd_word[15:8];
        end else if (hit_low) begin
          next_rdata = rd_word[7:0];
        end
      end
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ****************************************
  // Notes
  // ****************************************

  // The word is held only for the arbiter to send.
  // Page sequencing itself lives outside this block.
  // Limitation: a base and next page pulse together
  // count as a base page only.

endmodule

// File: verif/np_tx_checker_assertions.sv
// Checker: port 1 word, toggle and read data timing.
// Assumes it is bound into every design instance.
module np_tx_checker #(
  parameter NUM_PORTS = 3
) (
  input wire                     clk_sys_in,
  input wire                     arst_n_in,
  input wire                     reg_rd_in,
  input wire [7:0]               reg_addr_in,
  input wire [7:0]               reg_rdata_out,
  input wire [NUM_PORTS-1:0]     auto_eee_in,
  input wire [NUM_PORTS-1:0]     base_toggle_in,
  input wire [NUM_PORTS-1:0]     base_sent_in,
  input wire [NUM_PORTS-1:0]     page_sent_in,
  input wire [16*NUM_PORTS-1:0]  np_word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire u = auto_eee_in[0], g = page_sent_in[0], b = base_sent_in[0], t = np_word_out[11];
  wire [15:0] w = np_word_out[15:0];
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  property p_res; !w[14]; endproperty
  a_res: assert property (p_res) else $error("res");
  property p_tog; g && !b && !u |=> u || t != $past(t); endproperty
  a_tog: assert property (p_tog) else $error("tog");
  property p_base; b && !u |=> u || t == !$past(base_toggle_in[0]); endproperty
  a_base: assert property (p_base) else $error("base");
  property p_ro; !g && !b && !u |=> u || $stable(t); endproperty
  a_ro: assert property (p_ro) else $error("ro");
  property p_unm; reg_rd_in && !(reg_addr_in inside {8'h6E, 8'h6F, 8'hA0}) |=> reg_rdata_out == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unm");
  property p_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_rst; $rose(arst_n_in) && !u |-> w == 16'h2000; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_auto; u |-> w == 16'h0000; endproperty
  a_auto: assert property (p_auto) else $error("auto");
endmodule
bind an_next_page_tx_register np_tx_checker #(.NUM_PORTS(NUM_PORTS)) chk (
  .clk_sys_in     (clk_sys_in),
  .arst_n_in      (arst_n_in),
  .reg_rd_in      (reg_rd_in),
  .reg_addr_in    (reg_addr_in),
  .reg_rdata_out  (reg_rdata_out),
  .auto_eee_in    (auto_eee_in),
  .base_toggle_in (base_toggle_in),
  .base_sent_in   (base_sent_in),
  .page_sent_in   (page_sent_in),
  .np_word_out    (np_word_out)
);

// File: verif/an_next_page_tx_register_tb.sv
// Bench: byte window, toggle, auto mode.
// Assumes design and checker compiled first.
module an_next_page_tx_register_tb;
  timeunit 1ns; timeprecision 1ps;
  logic c = 0, r = 0, wr = 0, rd = 0;
  logic [7:0] a = 0, d = 0, q;
  logic [2:0] au = 0, bt = 0, bs = 0, ps = 0;
  wire [47:0] w;
  int error_cnt, num_checks, p, o, v, seed = 32'hf068, m[4] = '{4{32'h2000}};
  an_next_page_tx_register dut (.clk_sys_in(c), .arst_n_in(r), .reg_addr_in(a), .reg_wdata_in(d), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(q), .auto_eee_in(au), .base_toggle_in(bt), .base_sent_in(bs), .page_sent_in(ps),
    .np_word_out(w));
  initial forever #4 c = ~c;
  task ck(string n, logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end
  endtask
  task acc(logic [7:0] x, y, logic k);
    @(posedge c) #1 {a, d, wr, rd} = {x, y, !k, k};
    @(posedge c) #1 {wr, rd} = 0;
  endtask
  task test_done;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge c);
    #1 r = 1;
    for (p = 1; p < 4; p++) begin
      acc(8'h6E, 8'(32 + p), 0);
      for (o = 14; o < 16; o++) begin
        v = $random(seed);
        acc(8'h6F, 8'(o), 0);
        acc(8'hA0, 8'(v), 0);
        m[p] = o > 14 ? m[p] & 16'hFF00 | v & 16'h00FF : m[p] & 16'h08FF | v << 8 & 16'hB700;
        acc(8'hA0, 0, 1);
        ck("byte", q, 16'(m[p] >> 8 * (15 - o) & 16'h00FF));
      end
      @(posedge c) #1 {bt, bs} = {3'(v), 3'(1 << p - 1)};
      @(posedge c) #1 {ps, bs} = {bs, 3'h0};
      m[p] = m[p] & 16'hF7FF | !bt[p - 1] << 11;
      ck("word", w[p * 16 - 1 -: 16], 16'(m[p]));
      @(posedge c) #1 ps = 0;
      m[p] = m[p] ^ 16'h0800;
      ck("toggle", w[p * 16 - 1 -: 16], 16'(m[p]));
    end
    @(posedge c) #1 r = 0;
    @(posedge c) #1 r = 1;
    ck("reset word", w[15:0], 16'h2000);
    ck("reset page type", w[13], 1);
    acc(8'h55, 0, 1);
    ck("unmapped", q, 0);
    au = 1;
    #8 ck("auto", w[15:0], 0);
    test_done;
  end
endmodule
